// File: design/smart_params.svh
// Offsets, codes and reset values of the SMART sector builder.
// Assumes inclusion by bare name from design files.
`ifndef SMART_PARAMS_SVH
`define SMART_PARAMS_SVH
// ==========================================
// Register map (byte addresses)
`define OFS_CMD      12'h000
`define OFS_RES      12'h004
`define OFS_SEL      12'h008
`define OFS_CNT      12'h00C
`define WIN_BIT      11
// ==========================================
// Sector layout
`define THR_REV      16'h0010
`define THR_END      9'h16A
`define THR_LEN      12
`define ELOG_VER     8'h01
`define ELOG_LEN     90
`define ELOG_END     9'h1C4
`define ELOG_CNT     9'h1C4
`define ELOG_RECS    3'h5
`define ST_REV       16'h0001
`define ST_LEN       24
`define ST_USED      9
`define ST_END       9'h1FA
`define ST_PTR       9'h1FC
`define ST_DESCS     5'h15
`define CSUM_OFS     9'h1FF
`define CSUM_LAST    9'h1FE
`define CNT_MAX      16'hFFFF
`define THR_DEFAULT  {448'h0, 16'h1403, 16'h3201}
// ==========================================
// Command codes and answers
`define KEY_LO       8'h4F
`define KEY_HI       8'hC2
`define SUB_RD_DATA  8'hD0
`define SUB_RD_THR   8'hD1
`define SUB_AUTOSAVE 8'hD2
`define SUB_SAVE     8'hD3
`define SUB_OFFLINE  8'hD4
`define SUB_RD_LOG   8'hD5
`define SUB_ENABLE   8'hD8
`define SUB_DISABLE  8'hD9
`define SUB_STATUS   8'hDA
`define STS_OK       8'h50
`define STS_ERR      8'h51
`define ERR_NONE     8'h00
`define ERR_ABORT    8'h04
`define ERR_RD       8'h40
`define ERR_WR       8'h01
`endif

// File: design/smart_pkg.sv
// Types of the SMART sector builder.
// Assumes nothing beyond a SystemVerilog compiler.
package smart_pkg;
  // ==========================================
  // Snapshots, least significant byte = offset 0
  typedef struct packed {
    logic [31:0] time_ms;
    logic [7:0]  cmd;
    logic [7:0]  dev_head;
    logic [7:0]  cyl_hi;
    logic [7:0]  cyl_lo;
    logic [7:0]  sec_num;
    logic [7:0]  sec_cnt;
    logic [7:0]  features;
    logic [7:0]  dev_ctl;
  } cmd_snap_s;
  typedef struct packed {
    logic [15:0]  hours;
    logic [7:0]   state;
    logic [151:0] vendor;
    logic [7:0]   status;
    logic [7:0]   dev_head;
    logic [7:0]   cyl_hi;
    logic [7:0]   cyl_lo;
    logic [7:0]   sec_num;
    logic [7:0]   sec_cnt;
    logic [7:0]   error;
    logic [7:0]   rsvd;
  } err_snap_s;
  typedef struct packed {
    err_snap_s       snap;
    cmd_snap_s [4:0] cmds;
  } err_rec_s;
  typedef struct packed {
    logic [31:0] lba;
    logic [7:0]  chkpt;
    logic [15:0] hours;
    logic [7:0]  status;
    logic [7:0]  num;
  } st_desc_s;
  typedef enum logic [3:0] {
    DS_UNKNOWN  = 4'h0,
    DS_SLEEP    = 4'h1,
    DS_STANDBY  = 4'h2,
    DS_ACTIVE   = 4'h3,
    DS_SELFTEST = 4'h4
  } dev_state_e;
  typedef enum logic [1:0] {
    SEC_THR  = 2'h0,
    SEC_ELOG = 2'h1,
    SEC_ST   = 2'h2
  } sector_e;
  typedef enum logic {
    CS_IDLE = 1'b0,
    CS_RUN  = 1'b1
  } csum_state_e;
endpackage

// File: design/smart_csum.sv
// Checksum walker: sums bytes 0..510 of one sector, one per clock.
// Assumes the byte at addr is presented combinationally on data.
`timescale 1ns/10ps
`include "smart_params.svh"
module smart_csum (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       restart,
  input  wire logic [7:0] data,
  output logic      [8:0] addr,
  output logic            busy,
  output logic      [7:0] sum_out
);
  smart_pkg::csum_state_e state;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic       last;
  logic [9:0] run_cnt;

  assign next_acc = acc + data;
  assign last     = (addr == `CSUM_LAST);
  assign busy     = (state == smart_pkg::CS_RUN);

  // ==========================================
  // Walk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= smart_pkg::CS_RUN;
      addr    <= 9'h000;
      acc     <= 8'h00;
      sum_out <= 8'h00;
    end else if (restart) begin
      state <= smart_pkg::CS_RUN;
      addr  <= 9'h000;
      acc   <= 8'h00;
    end else begin
      case (state)
        smart_pkg::CS_RUN: begin
          acc  <= next_acc;
          addr <= addr + 9'h001;
          if (last) begin
            sum_out <= 8'h00 - next_acc;
            state   <= smart_pkg::CS_IDLE;
          end
        end
        default: state <= smart_pkg::CS_IDLE;
      endcase
    end
  end

  // ==========================================
  // Checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= 10'h000;
    end else begin
      run_cnt <= (restart || !busy) ? 10'h000 : run_cnt + 10'h001;
    end
  end
  a_walk_length: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(busy) && !$past(restart)) |-> $past(run_cnt) == 10'h1FE)
    else $error("checksum walk not 511 bytes");
endmodule

// File: design/smart_log_sector_builder.sv
// SMART sector builder: threshold, error log and self-test log sectors.
// Assumes an Avalon-MM master and event strobes synchronous to CLK.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "smart_params.svh"
// Functional notes
// - Last sector byte makes the 8-bit sum of all 512 bytes zero.
// - Threshold sector: revision 0010h, thirty entries, zero reserved areas.
// - Multibyte fields go out least significant byte first.
// - Threshold entries keep the order of the attribute value entries.
// - Threshold entry: ID byte, threshold byte, ten zero bytes.
// - Thresholds are factory constants no command can change.
// - Error log: version 01h, pointer, five records, count, reserved.
// - Error log pointer names the newest record, only 1 to 5.
// - Error count increments per logged error and saturates.
// - Error record: five command snapshots then an error snapshot.
// - Command snapshot: eight taskfile bytes then 4-byte millisecond time.
// - Error snapshot: taskfile, status, vendor bytes, state, hours.
// - State byte low nibble encodes device state at command issue.
// - Self-test log: revision then 24-byte descriptors at n*18h+02h.
// - Descriptor: number, status, hours, checkpoint, LBA, vendor bytes.
// - Newest self-test result overwrites oldest after 21 descriptors.
// - Self-test pointer at 1FCh: 0 when empty, else 1 to 21.
// - Missing key aborts with status 51h, error 04h.
// - Invalid subcommand aborts with status 51h, error 04h.
// - Only enable subcommand is accepted while SMART is disabled.
// - Attribute read failure answers 51h with error 40h.
// - Attribute write failure answers 51h with error 01h.
module smart_log_sector_builder #(
  parameter logic [479:0] THR_TABLE = `THR_DEFAULT
) (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic [11:0]           AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic                  ERR_EVT,
  input  wire smart_pkg::err_rec_s   ERR_REC,
  input  wire smart_pkg::dev_state_e DEV_STATE,
  input  wire logic                  ST_EVT,
  input  wire smart_pkg::st_desc_s   ST_DESC,
  input  wire logic                  ATTR_RD_FAIL,
  input  wire logic                  ATTR_WR_FAIL,
  output logic                       SMART_ENABLED
);
  // ==========================================
  // Storage
  smart_pkg::err_rec_s rec_mem [5];
  smart_pkg::st_desc_s st_mem [21];
  smart_pkg::err_rec_s next_rec;
  logic [2:0]  eptr;
  logic [2:0]  next_eptr;
  logic [15:0] err_cnt;
  logic [4:0]  sptr;
  logic [4:0]  next_sptr;
  logic [1:0]  sel;
  logic [7:0]  res_status;
  logic [7:0]  res_error;
  logic        smart_en;

  // ==========================================
  // Byte view of the selected sector
  function automatic logic [7:0] sector_byte(input logic [1:0] s,
                                             input logic [8:0] ofs);
    int         o;
    int         n;
    int         b;
    logic [7:0] v;
    logic [15:0] rev;
    v = 8'h00;
    o = int'(ofs);
    n = 0;
    b = 0;
    rev = 16'h0000;
    case (s)
      smart_pkg::SEC_THR: begin
        rev = `THR_REV;
        if (o < 2) begin
          v = rev[8*o +: 8];
        end else if (ofs < `THR_END) begin
          n = (o - 2) / `THR_LEN;
          b = (o - 2) % `THR_LEN;
          if (b < 2) begin
            v = THR_TABLE[16*n + 8*b +: 8];
          end
        end
      end
      smart_pkg::SEC_ELOG: begin
        if (o == 0) begin
          v = `ELOG_VER;
        end else if (o == 1) begin
          v = {5'h00, eptr};
        end else if (ofs < `ELOG_END) begin
          n = (o - 2) / `ELOG_LEN;
          b = (o - 2) % `ELOG_LEN;
          v = rec_mem[n][8*b +: 8];
        end else if (ofs == `ELOG_CNT) begin
          v = err_cnt[7:0];
        end else if (ofs == `ELOG_CNT + 9'h001) begin
          v = err_cnt[15:8];
        end
      end
      smart_pkg::SEC_ST: begin
        rev = `ST_REV;
        if (o < 2) begin
          v = rev[8*o +: 8];
        end else if (ofs < `ST_END) begin
          n = (o - 2) / `ST_LEN;
          b = (o - 2) % `ST_LEN;
          if (b < `ST_USED) begin
            v = st_mem[n][8*b +: 8];
          end
        end else if (ofs == `ST_PTR) begin
          v = {3'h0, sptr};
        end
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================
  // Checksum walker
  logic [8:0] cs_addr;
  logic [7:0] cs_data;
  logic [7:0] cs_sum;
  logic       cs_busy;
  logic       restart;
  logic       sel_wr;

  always_comb begin
    cs_data = sector_byte(sel, cs_addr);
  end

  // Any content or view change restarts the walk so a stale checksum
  // can never be served.
  assign restart = ERR_EVT | ST_EVT | sel_wr;

  smart_csum u_csum (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .restart (restart),
    .data    (cs_data),
    .addr    (cs_addr),
    .busy    (cs_busy),
    .sum_out (cs_sum)
  );

  // ==========================================
  // Bus decode
  wire        win     = AVS_ADDRESS[`WIN_BIT];
  wire [8:0]  win_ofs = AVS_ADDRESS[10:2];
  wire        wr_cmd  = AVS_WRITE & (AVS_ADDRESS == `OFS_CMD) & AVS_BYTEENABLE[0];
  assign      sel_wr  = AVS_WRITE & (AVS_ADDRESS == `OFS_SEL) & AVS_BYTEENABLE[0];
  logic       rd_ack;
  logic [7:0] win_byte;
  logic [31:0] rd_mux;

  always_comb begin
    win_byte = sector_byte(sel, win_ofs);
    if (win_ofs == `CSUM_OFS) begin
      win_byte = cs_sum;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (win) begin
      rd_mux = {24'h00_0000, win_byte};
    end else begin
      case (AVS_ADDRESS)
        `OFS_RES: rd_mux = {15'h0000, smart_en, res_error, res_status};
        `OFS_SEL: rd_mux = {30'h0000_0000, sel};
        `OFS_CNT: rd_mux = {3'h0, sptr, 5'h00, eptr, err_cnt};
        default:  rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // A window read stalls while the checksum is being rebuilt.
  wire rd_hold = win & (cs_busy | restart);
  wire rd_take = AVS_READ & ~rd_ack & ~rd_hold;
  assign AVS_WAITREQUEST = AVS_READ & ~rd_ack;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_ack       <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      rd_ack <= rd_take;
      if (rd_take) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel <= 2'h0;
    end else if (sel_wr) begin
      sel <= AVS_WRITEDATA[1:0];
    end
  end

  // ==========================================
  // Command check
  wire [7:0] feat    = AVS_WRITEDATA[7:0];
  wire       key_ok  = (AVS_WRITEDATA[15:8] == `KEY_LO) & (AVS_WRITEDATA[23:16] == `KEY_HI);
  wire       sub_ok  = (feat == `SUB_RD_DATA) | (feat == `SUB_RD_THR) | (feat == `SUB_AUTOSAVE)
                     | (feat == `SUB_SAVE) | (feat == `SUB_OFFLINE) | (feat == `SUB_RD_LOG)
                     | (feat == `SUB_ENABLE) | (feat == `SUB_DISABLE) | (feat == `SUB_STATUS);
  wire       abort   = ~key_ok | ~sub_ok | (~smart_en & (feat != `SUB_ENABLE));
  wire       rd_fail = ATTR_RD_FAIL & ((feat == `SUB_RD_DATA) | (feat == `SUB_RD_THR));
  wire       wr_fail = ATTR_WR_FAIL & ((feat == `SUB_SAVE) | (feat == `SUB_AUTOSAVE));
  wire [7:0] next_status = (abort | rd_fail | wr_fail) ? `STS_ERR : `STS_OK;
  wire [7:0] next_error  = abort ? `ERR_ABORT
                         : rd_fail ? `ERR_RD
                         : wr_fail ? `ERR_WR
                         : `ERR_NONE;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_status <= `STS_OK;
      res_error  <= `ERR_NONE;
      smart_en   <= 1'b0;
    end else if (wr_cmd) begin
      res_status <= next_status;
      res_error  <= next_error;
      if (!abort && feat == `SUB_ENABLE) begin
        smart_en <= 1'b1;
      end else if (!abort && feat == `SUB_DISABLE) begin
        smart_en <= 1'b0;
      end
    end
  end
  assign SMART_ENABLED = smart_en;

  // ==========================================
  // Error log update, one clock so no partial record is visible
  always_comb begin
    next_rec = ERR_REC;
    next_rec.snap.state[3:0] = DEV_STATE;
  end
  assign next_eptr = (eptr == `ELOG_RECS) ? 3'h1 : eptr + 3'h1;
  assign next_sptr = (sptr == `ST_DESCS) ? 5'h01 : sptr + 5'h01;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eptr    <= `ELOG_RECS;
      err_cnt <= 16'h0000;
      for (int i = 0; i < 5; i++) begin
        rec_mem[i] <= '0;
      end
    end else if (ERR_EVT) begin
      rec_mem[next_eptr - 3'h1] <= next_rec;
      eptr <= next_eptr;
      if (err_cnt != `CNT_MAX) begin
        err_cnt <= err_cnt + 16'h0001;
      end
    end
  end

  // ==========================================
  // Self-test log update
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sptr <= 5'h00;
      for (int i = 0; i < 21; i++) begin
        st_mem[i] <= '0;
      end
    end else if (ST_EVT) begin
      st_mem[next_sptr - 5'h01] <= ST_DESC;
      sptr <= next_sptr;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_eptr_range: assert property (eptr >= 3'h1 && eptr <= `ELOG_RECS)
    else $error("error log pointer out of range");
  a_eptr_step: assert property (ERR_EVT |=>
    eptr == (($past(eptr) == `ELOG_RECS) ? 3'h1 : $past(eptr) + 3'h1))
    else $error("error log pointer did not advance");
  a_cnt_sat: assert property (ERR_EVT && err_cnt == `CNT_MAX |=> err_cnt == `CNT_MAX)
    else $error("error count wrapped");
  a_cnt_inc: assert property (ERR_EVT && err_cnt != `CNT_MAX |=> err_cnt == $past(err_cnt) + 16'h0001)
    else $error("error count did not increment");
  a_sptr_wrap: assert property (ST_EVT && sptr == `ST_DESCS |=> sptr == 5'h01)
    else $error("self-test pointer did not wrap");
  a_sptr_range: assert property (sptr <= `ST_DESCS)
    else $error("self-test pointer out of range");
  a_key_abort: assert property (wr_cmd && !key_ok |=>
    res_status == `STS_ERR && res_error == `ERR_ABORT)
    else $error("missing key not aborted");
  a_sub_abort: assert property (wr_cmd && !sub_ok |=> res_error == `ERR_ABORT)
    else $error("bad subcommand not aborted");
  a_dis_abort: assert property (wr_cmd && !smart_en && feat != `SUB_ENABLE |=>
    res_status == `STS_ERR && !smart_en)
    else $error("command accepted while disabled");
  a_rd_fail: assert property (wr_cmd && !abort && rd_fail |=> res_error == `ERR_RD)
    else $error("read failure not reported");
  a_wr_fail: assert property (wr_cmd && !abort && wr_fail |=> res_error == `ERR_WR)
    else $error("write failure not reported");
  // Window data must have been captured only after the walk had settled
  a_win_stall: assert property (rd_ack && win |-> !$past(cs_busy) && !$past(restart))
    else $error("window read served during checksum rebuild");
  a_state_nib: assert property (ERR_EVT |=>
    rec_mem[eptr - 3'h1].snap.state[3:0] == $past(DEV_STATE))
    else $error("state nibble not taken from device state");
  a_rd_answer: assert property (AVS_READ && !win && !rd_ack |=> rd_ack)
    else $error("register read not answered in one cycle");

  c_err_log: cover property (ERR_EVT && eptr == `ELOG_RECS);
  c_st_wrap: cover property (ST_EVT && sptr == `ST_DESCS);
  c_abort: cover property (wr_cmd && abort);
  c_win_read: cover property (AVS_READ && win && rd_ack && win_ofs == `CSUM_OFS);
endmodule

// File: sim/smart_host_model.sv
// Host adapter model: an Avalon-MM master issuing SMART commands and sector reads.
// Assumes one caller at a time; each transfer is bounded and reports a timeout.
`timescale 1ns/10ps
module smart_host_model (
  input  wire logic        CLK,
  output logic      [11:0] AVS_ADDRESS,
  output logic             AVS_READ,
  output logic             AVS_WRITE,
  output logic      [31:0] AVS_WRITEDATA,
  output logic      [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_READDATA,
  input  wire logic        AVS_WAITREQUEST
);
  initial begin
    AVS_ADDRESS = 12'hFFF;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'hFFFFFFFF;
    AVS_BYTEENABLE = 4'hF;
  end
  // ==========================================
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    ok = 1'b0;
    q = 32'h0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    if (wr) AVS_WRITE <= 1'b1;
    else AVS_READ <= 1'b1;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) begin
        ok = 1'b1;
        q = AVS_READDATA;
      end
    end
    // Idle lines carry the inverse so a stale value never looks valid
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    AVS_ADDRESS <= ~a;
    AVS_WRITEDATA <= ~d;
  endtask
endmodule

// File: sim/smart_log_sector_builder_tb_top.sv
// Bench for the SMART sector builder: commands, three sectors, logging events.
// Assumes the host model drives the register bus; events come from here.
`timescale 1ns/10ps
`include "smart_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module smart_log_sector_builder_tb_top;
  function automatic logic [479:0] mk_thr();
    for (int k = 0; k < 30; k++) mk_thr[16*k +: 16] = {8'h20 + 8'(k), 8'h01 + 8'(3*k)};
  endfunction
  localparam logic [479:0] THR_TBL = mk_thr();
  logic                  clk, arst_n, avs_read, avs_write, avs_waitrequest, smart_enabled;
  logic [11:0]           avs_address;
  logic [31:0]           avs_writedata, avs_readdata, q;
  logic [3:0]            avs_byteenable;
  logic                  err_evt, st_evt, attr_rd_fail, attr_wr_fail;
  smart_pkg::err_rec_s   err_rec;
  smart_pkg::dev_state_e dev_state;
  smart_pkg::st_desc_s   st_desc;
  int                    failures, num_checks;
  logic [7:0]            sec [512];
  smart_pkg::dev_state_e st_tab [5] = '{smart_pkg::DS_UNKNOWN, smart_pkg::DS_SLEEP,
    smart_pkg::DS_STANDBY, smart_pkg::DS_ACTIVE, smart_pkg::DS_SELFTEST};

  smart_log_sector_builder #(.THR_TABLE(THR_TBL)) smart_log_sector_builder_i (
    .CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .ERR_EVT(err_evt),
    .ERR_REC(err_rec), .DEV_STATE(dev_state), .ST_EVT(st_evt), .ST_DESC(st_desc),
    .ATTR_RD_FAIL(attr_rd_fail), .ATTR_WR_FAIL(attr_wr_fail), .SMART_ENABLED(smart_enabled));
  smart_host_model smart_host_model_i (
    .CLK(clk), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Helpers
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    bit ok;
    smart_host_model_i.xfer(wr, a, d, q, ok);
    if (!ok) begin
      failures++;
      $display("BAD bus answer at %0h", a);
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] sub, input logic [15:0] key, input logic [15:0] exp);
    bus(1'b1, `OFS_CMD, {8'h00, key, sub});
    bus(1'b0, `OFS_RES, 32'h0);
    `CHK("status/error", exp, q[15:0])
  endtask
  task automatic dump(input logic [1:0] sel);
    logic [7:0] sum;
    sum = 8'h00;
    bus(1'b1, `OFS_SEL, {30'h0, sel});
    for (int i = 0; i < 512; i++) begin
      bus(1'b0, 12'h800 + 12'(4*i), 32'h0);
      sec[i] = q[7:0];
      sum += q[7:0];
    end
    `CHK("sector sum", 8'h00, sum)
  endtask
  function automatic logic [7:0] eb(int k, int i);
    return 8'(k) ^ 8'(17*i);
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_reset();
    bus(1'b0, `OFS_CNT, 32'h0);
    `CHK("err count", 16'h0000, q[15:0])
    `CHK("err pointer", 3'd5, q[18:16])
    `CHK("st pointer", 5'd0, q[28:24])
    $display("test reset done");
  endtask
  task automatic t_cmds();
    logic [7:0] bad [5] = '{8'h00, 8'hD6, 8'hD7, 8'hDB, 8'hFF};
    logic [7:0] good [7] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hDA};
    cmd(8'hD0, 16'hC24F, 16'h0451);
    cmd(8'hD8, 16'hC200, 16'h0451);
    cmd(8'hD8, 16'h004F, 16'h0451);
    cmd(8'hD8, 16'hC24F, 16'h0050);
    `CHK("enabled", 1'b1, smart_enabled)
    foreach (bad[i]) cmd(bad[i], 16'hC24F, 16'h0451);
    foreach (good[i]) cmd(good[i], 16'hC24F, 16'h0050);
    @(posedge clk) attr_rd_fail <= 1'b1;
    cmd(8'hD0, 16'hC24F, 16'h4051);
    cmd(8'hD1, 16'hC24F, 16'h4051);
    @(posedge clk) attr_rd_fail <= 1'b0;
    attr_wr_fail <= 1'b1;
    cmd(8'hD2, 16'hC24F, 16'h0151);
    cmd(8'hD3, 16'hC24F, 16'h0151);
    @(posedge clk) attr_wr_fail <= 1'b0;
    cmd(8'hD9, 16'hC24F, 16'h0050);
    `CHK("disabled", 1'b0, smart_enabled)
    cmd(8'hDA, 16'hC24F, 16'h0451);
    cmd(8'hD8, 16'hC24F, 16'h0050);
    $display("test commands done");
  endtask
  task automatic t_thr();
    logic [7:0] z;
    z = 8'h00;
    dump(2'd0);
    `CHK("thr revision", 16'h0010, {sec[1], sec[0]})
    for (int k = 0; k < 30; k++) begin
      `CHK("thr id", THR_TBL[16*k +: 8], sec[2+12*k])
      `CHK("thr value", THR_TBL[16*k+8 +: 8], sec[3+12*k])
      for (int j = 2; j < 12; j++) z |= sec[2+12*k+j];
    end
    for (int i = 9'h16A; i < 9'h1FF; i++) z |= sec[i];
    `CHK("thr zero bytes", 8'h00, z)
    $display("test thresholds done");
  endtask
  task automatic t_elog();
    logic [719:0] r;
    logic [7:0]   z;
    int           b, i;
    z = 8'h00;
    for (int e = 1; e <= 6; e++) begin
      for (int k = 0; k < 90; k++) r[8*k +: 8] = eb(k, e);
      @(posedge clk);
      err_rec <= smart_pkg::err_rec_s'(r);
      dev_state <= st_tab[(e-1)%5];
      err_evt <= 1'b1;
      @(posedge clk) err_evt <= 1'b0;
      bus(1'b0, `OFS_CNT, 32'h0);
      `CHK("err pointer", 3'((e-1)%5+1), q[18:16])
      `CHK("err count", 16'(e), q[15:0])
    end
    dump(2'd1);
    `CHK("log version", 8'h01, sec[0])
    `CHK("log pointer", 8'h01, sec[1])
    `CHK("log count", 16'h0006, {sec[9'h1C5], sec[9'h1C4]})
    for (int n = 9'h1C6; n < 9'h1FF; n++) z |= sec[n];
    `CHK("log reserved", 8'h00, z)
    for (int n = 1; n <= 5; n++) begin
      b = 2 + 90*(n-1);
      i = (n == 1) ? 6 : n;
      `CHK("cmd snap ctl", eb(0, i), sec[b])
      `CHK("cmd snap time", eb(8, i), sec[b+8])
      `CHK("cmd snap 5", eb(9'h30, i), sec[b+9'h30])
      `CHK("err snap status", eb(9'h43, i), sec[b+9'h43])
      `CHK("err snap state", {eb(9'h57, i) >> 4, st_tab[(i-1)%5]}, sec[b+9'h57])
      `CHK("err snap hours", {eb(9'h59, i), eb(9'h58, i)}, {sec[b+9'h59], sec[b+9'h58]})
    end
    $display("test error log done");
  endtask
  task automatic t_st();
    logic [7:0] z;
    z = 8'h00;
    for (int e = 1; e <= 22; e++) begin
      @(posedge clk);
      st_desc <= {32'hA1B2C300 | 32'(e), 8'h60 + 8'(e), 16'h0100 + 16'(e), 8'h70, 8'(e)};
      st_evt <= 1'b1;
      @(posedge clk) st_evt <= 1'b0;
      bus(1'b0, `OFS_CNT, 32'h0);
      `CHK("st pointer", 5'((e-1)%21+1), q[28:24])
    end
    dump(2'd2);
    `CHK("st revision", `ST_REV, {sec[1], sec[0]})
    `CHK("newest in slot 0", 8'd22, sec[2])
    `CHK("slot 20 number", 8'd21, sec[9'h1E2])
    `CHK("st status", 8'h70, sec[3])
    `CHK("st hours", 16'h0116, {sec[5], sec[4]})
    `CHK("st checkpoint", 8'h76, sec[6])
    `CHK("st lba", 32'hA1B2C316, {sec[10], sec[9], sec[8], sec[7]})
    for (int n = 9'h0D; n < 9'h1A; n++) z |= sec[n];
    `CHK("st vendor", 8'h00, z)
    `CHK("st log pointer", 8'h01, sec[9'h1FC])
    $display("test self-test log done");
  endtask
  task automatic t_sat();
    // Count is 6 after the log test; a long burst pushes it two past the maximum
    @(posedge clk) err_evt <= 1'b1;
    repeat (65531) @(posedge clk);
    err_evt <= 1'b0;
    bus(1'b0, `OFS_CNT, 32'h0);
    `CHK("err count saturated", 16'hFFFF, q[15:0])
    `CHK("err pointer wrapped", 3'd2, q[18:16])
    $display("test count saturation done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    arst_n = 1'b0;
    err_evt = 1'b0;
    st_evt = 1'b0;
    err_rec = '0;
    st_desc = '0;
    dev_state = smart_pkg::DS_ACTIVE;
    attr_rd_fail = 1'b0;
    attr_wr_fail = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_cmds();
    t_thr();
    t_elog();
    t_st();
    t_sat();
    conclude();
  end
endmodule
